// *** lhr_heartbeat_relay_tb_top.sv ***
// Self-checking bench of the heartbeat relay
module lhr_heartbeat_relay_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    lhr_pkg::lhr_bus_req_t bus = '0;
    lhr_pkg::lhr_meas_t ms = '0;
    logic slow = 1'b0;
    logic [31:0] rdata;
    logic irq, rxv, rxf, txv, txr, mst, mon, wake;
    logic [7:0] rxd, txd, c, f, v, mff;
    int miscompares = 0;
    int cmp_count = 0;
    integer seed = 32'hd5e6c266;
    int k, n0;
    always #20 clk_sys_i = ~clk_sys_i;
    lhr_relay #(.FIRST_CYC(20), .PERIOD_CYC(200), .TMO_CYC(400)) u_dut (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata), .irq_o(irq), .rx_valid_i(rxv), .rx_first_i(rxf),
        .rx_data_i(rxd), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .meas_start_o(mst), .meas_i(ms),
        .monitoring_o(mon), .wake_o(wake));
    lhr_nbr_model u_nbr (.clk_sys_i(clk_sys_i), .slow_i(slow), .rx_valid_o(rxv), .rx_first_o(rxf),
        .rx_data_o(rxd), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr));
    function automatic logic [15:0] crc(input logic [15:0] s, input logic [15:0] d);
        logic [15:0] r;
        r = s;
        for (int i = 15; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? lhr_pkg::PEC_POLY : 16'h0000);
        return r;
    endfunction
    function automatic logic [63:0] frm(input logic [7:0] cn, input logic [7:0] fl);
        return {lhr_pkg::HB_CMD_CODE, crc(lhr_pkg::CMD_SEED, lhr_pkg::HB_CMD_CODE), cn, fl,
            crc(lhr_pkg::DATA_SEED, {cn, fl})};
    endfunction
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    // Measurement engine stand-in: answers each start after a random delay
    task meas(input logic [7:0] vi, input logic dg, output int kk);
        kk = 300;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_sys_i);
            if (mst === 1'b1) begin
                kk = i;
                break;
            end
        end
        if (kk < 300) begin
            repeat (1 + ($random(seed) & 7)) @(posedge clk_sys_i);
            ms <= '{1'b1, vi, dg};
            @(posedge clk_sys_i);
            ms.done <= 1'b0;
        end
    endtask
    task take(input logic [63:0] e);
        for (int i = 0; i < 300 && u_nbr.n < n0 + 8; i++) @(posedge clk_sys_i);
        chk("frame", e, u_nbr.got);
    endtask
    task hop(input logic dg);
        n0 = u_nbr.n;
        fork
            u_nbr.send(frm(c, f));
            meas(v, dg, k);
        join
        chk("early tx", n0, u_nbr.n);
        mff = dg ? lhr_pkg::ALL_FAULT : (mff | v);
        take(frm((v == 8'h00 && !dg) ? c - 8'h01 : c, f | mff));
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(40 * 8000);
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        rchk("len", lhr_pkg::REG_LEN, 32'h43);
        rchk("mff", lhr_pkg::REG_MFF, 32'h0);
        wr(lhr_pkg::REG_CLRMF, 32'hFFFF);
        wr(lhr_pkg::REG_IMASK, 32'h1);
        wr(lhr_pkg::REG_CMD, 32'h1);
        #1 chk("mon", 1, mon);
        mff = 8'h00;
        for (int j = 0; j < 6; j++) begin
            slow <= j[0];
            c = 8'h43 + 8'($random(seed) & 15);
            f = 8'($random(seed));
            v = ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
            hop(1'b0);
        end
        hop(1'b1);
        rchk("mff", lhr_pkg::REG_MFF, 32'hFF);
        wr(lhr_pkg::REG_CLRMF, 32'hFFFF);
        rchk("mff", lhr_pkg::REG_MFF, 32'h0);
        n0 = u_nbr.n;
        fork
            u_nbr.send(frm(c, f) ^ 64'h1);
            meas(8'h00, 1'b0, k);
        join
        chk("drop", 300, k);
        chk("drop tx", n0, u_nbr.n);
        chk("irq", 1, irq);
        // Sent-frame bit stays set from the relay hops above
        rchk("ist", lhr_pkg::REG_IST, 32'h3);
        wr(lhr_pkg::REG_IST, 32'hF);
        #1 chk("irq", 0, irq);
        wr(lhr_pkg::REG_CMD, 32'h2);
        wr(lhr_pkg::REG_CTRL, 32'h2);
        wr(lhr_pkg::REG_IMASK, 32'hC);
        wr(lhr_pkg::REG_CMD, 32'h1);
        #1 chk("wake", 1, wake);
        u_nbr.send(frm(8'h42, 8'h00));
        repeat (3) @(posedge clk_sys_i);
        chk("wake", 0, wake);
        u_nbr.send(frm(8'h42, 8'h01));
        repeat (3) @(posedge clk_sys_i);
        chk("wake", 1, wake);
        chk("irq", 1, irq);
        rchk("ist", lhr_pkg::REG_IST, 32'h4);
        rchk("lastrx", lhr_pkg::REG_LASTRX, 32'h4201);
        wr(lhr_pkg::REG_IST, 32'hF);
        u_nbr.send(frm(8'h42, 8'h00));
        repeat (405) @(posedge clk_sys_i);
        chk("wake", 1, wake);
        rchk("ist", lhr_pkg::REG_IST, 32'h8);
        wr(lhr_pkg::REG_CMD, 32'h2);
        wr(lhr_pkg::REG_CTRL, 32'h1);
        wr(lhr_pkg::REG_LEN, 32'h48);
        wr(lhr_pkg::REG_CMD, 32'h1);
        n0 = u_nbr.n;
        meas(8'h00, 1'b0, k);
        chk("first delay", 1, k >= 19 && k <= 22);
        take(frm(8'h47, 8'h00));
        wr(lhr_pkg::REG_CMD, 32'h2);
        end_of_test;
    end
endmodule

// *** lhr_nbr_model.sv ***
// Neighbour monitor model: upstream frame source and downstream byte sink
module lhr_nbr_model (
    // Clock and stall mode
    input wire logic clk_sys_i,
    input wire logic slow_i,
    // Upstream side
    output logic rx_valid_o,
    output logic rx_first_o,
    output logic [7:0] rx_data_o,
    // Downstream side
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] got = 64'h0;
    int n = 0;
    logic [1:0] ph = 2'h0;
    initial begin
        rx_valid_o = 1'b0;
        rx_first_o = 1'b0;
        rx_data_o = 8'h5A;
        tx_ready_o = 1'b0;
    end
    // Slow mode takes one byte in four to stretch the sender
    always @(posedge clk_sys_i) begin
        ph <= ph + 2'h1;
        tx_ready_o <= !slow_i || (ph == 2'h3);
        if (tx_valid_i && tx_ready_o) begin
            got <= {got[55:0], tx_data_i};
            n <= n + 1;
        end
    end
    task automatic send(input logic [63:0] f);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_i);
            rx_valid_o <= 1'b1;
            rx_first_o <= (i == 0);
            rx_data_o <= f[63 - 8 * i -: 8];
        end
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_first_o <= 1'b0;
        // Released line must not keep showing the last byte
        rx_data_o <= ~rx_data_o;
    endtask
endmodule

// *** lhr_pec.sv ***
// Two-byte check value generator shared by command and data checks
module lhr_pec (
    // Seed and bytes
    input wire logic [15:0] seed_i,
    input wire logic [7:0] byte0_i,
    input wire logic [7:0] byte1_i,
    // Result
    output logic [15:0] check_o
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ lhr_pkg::PEC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    assign check_o = crc_step(crc_step(seed_i, byte0_i), byte1_i);
endmodule

// *** lhr_pkg.sv ***
// Constants, types and register map of the heartbeat relay
package lhr_pkg;
    // Timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned FIRST_HB_MS = 31;
    localparam int unsigned FIRST_HB_CYC = FIRST_HB_MS * CYC_PER_MS;
    localparam int unsigned PERIOD_MS = 1000;
    localparam int unsigned PERIOD_CYC = PERIOD_MS * CYC_PER_MS;
    localparam int unsigned TMO_MS = 3000;
    localparam int unsigned TMO_CYC = TMO_MS * CYC_PER_MS;

    // Frame layout
    localparam logic [2:0] IDX_CMD0 = 3'h0;
    localparam logic [2:0] IDX_CMD1 = 3'h1;
    localparam logic [2:0] IDX_CCHK0 = 3'h2;
    localparam logic [2:0] IDX_CCHK1 = 3'h3;
    localparam logic [2:0] IDX_COUNT = 3'h4;
    localparam logic [2:0] IDX_FLAGS = 3'h5;
    localparam logic [2:0] IDX_DCHK0 = 3'h6;
    localparam logic [2:0] IDX_DCHK1 = 3'h7;

    // Command code value is arbitrary
    localparam logic [15:0] HB_CMD_CODE = 16'h0A5C;
    localparam logic [15:0] PEC_POLY = 16'h1021;
    localparam logic [15:0] CMD_SEED = 16'h0010;
    localparam logic [15:0] DATA_SEED = 16'h0010;

    // Payload values
    localparam logic [7:0] PASS_COUNT = 8'h42;
    localparam logic [7:0] PASS_FLAGS = 8'h00;
    localparam logic [7:0] ALL_FAULT = 8'hFF;
    localparam logic [7:0] LEN_RST = 8'h43;

    // Flag byte bit positions
    localparam int FLG_GDVP = 7;
    localparam int FLG_GDVN = 6;
    localparam int FLG_GOV = 5;
    localparam int FLG_GUV = 4;
    localparam int FLG_CDVP = 3;
    localparam int FLG_CDVN = 2;
    localparam int FLG_COV = 1;
    localparam int FLG_CUV = 0;

    // Register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_CLRMF = 4'h2;
    localparam logic [3:0] REG_LEN = 4'h3;
    localparam logic [3:0] REG_MFF = 4'h4;
    localparam logic [3:0] REG_LASTRX = 4'h5;
    localparam logic [3:0] REG_IST = 4'h6;
    localparam logic [3:0] REG_IMASK = 4'h7;
    localparam logic [3:0] REG_STAT = 4'h8;

    // Field positions
    localparam int CTRL_ORIG = 0;
    localparam int CTRL_TERM = 1;
    localparam int CMD_EN = 0;
    localparam int CMD_DIS = 1;
    localparam int IRQ_REJ = 0;
    localparam int IRQ_SENT = 1;
    localparam int IRQ_FAIL = 2;
    localparam int IRQ_TMO = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_MEAS = 2'b11,
        ST_SEND = 2'b10
    } lhr_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic [7:0] flags;
    } lhr_payload_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lhr_bus_req_t;

    typedef struct packed {
        logic done;
        logic [7:0] viol;
        logic diag_fail;
    } lhr_meas_t;
endpackage

// *** lhr_relay.sv ***
// Heartbeat frame receiver, checker, regenerator and chain-end evaluator
module lhr_relay #(
    parameter int unsigned FIRST_CYC = lhr_pkg::FIRST_HB_CYC,
    parameter int unsigned PERIOD_CYC = lhr_pkg::PERIOD_CYC,
    parameter int unsigned TMO_CYC = lhr_pkg::TMO_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Register port
    input wire lhr_pkg::lhr_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    // Upstream bytes
    input wire logic rx_valid_i,
    input wire logic rx_first_i,
    input wire logic [7:0] rx_data_i,
    // Downstream bytes
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // Measurement engine
    output logic meas_start_o,
    input wire lhr_pkg::lhr_meas_t meas_i,
    // Chain status
    output logic monitoring_o,
    output logic wake_o
);
    localparam int IRQ_W_M1 = lhr_pkg::IRQ_W - 1;

    lhr_pkg::lhr_state_t state, next_state;
    logic [31:0] timer, next_timer;
    logic active, next_active;
    logic orig, next_orig;
    logic term, next_term;
    logic [7:0] chain_len, next_len;
    logic [7:0] mff, next_mff;
    logic [IRQ_W_M1:0] irq_st, next_ist;
    logic [IRQ_W_M1:0] irq_mask, next_mask;
    logic [31:0] rdata, next_rdata;
    logic [7:0] rx_buf [0:7];
    logic [7:0] next_rx_buf [0:7];
    logic [2:0] rx_idx, next_rx_idx;
    lhr_pkg::lhr_payload_t last_rx, next_last_rx;
    lhr_pkg::lhr_payload_t in_pl, next_in_pl;
    lhr_pkg::lhr_payload_t tx_pl, next_tx_pl;
    logic [2:0] tx_idx, next_tx_idx;
    logic [7:0] tx_data, next_tx_data;
    logic [7:0] tx_frame [0:7];
    logic term_fault, next_term_fault;
    logic [31:0] tmo_cnt, next_tmo_cnt;
    logic cmd_en, cmd_dis, clr_wr, meas_take, own_fail, hb_sent;
    logic rx_done, rx_ok, rx_bad, rx_take, term_fail_ev, tmo_ev;
    logic [7:0] clr_mask, mff_meas;
    logic [15:0] rx_cchk, rx_dchk, tx_cchk, tx_dchk;
    logic [IRQ_W_M1:0] events;

    // Request is an argument so that continuous assigns re-evaluate on every bus change
    function automatic logic wr_hit(input lhr_pkg::lhr_bus_req_t b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    assign cmd_dis = wr_hit(bus_i, lhr_pkg::REG_CMD) && bus_i.wdata[lhr_pkg::CMD_DIS];
    assign cmd_en = wr_hit(bus_i, lhr_pkg::REG_CMD) && bus_i.wdata[lhr_pkg::CMD_EN] && !cmd_dis;
    assign clr_wr = wr_hit(bus_i, lhr_pkg::REG_CLRMF);
    // Both command data bytes must carry a one to clear a flag
    assign clr_mask = bus_i.wdata[7:0] & bus_i.wdata[15:8];
    assign meas_take = (state == lhr_pkg::ST_MEAS) && meas_i.done;
    assign own_fail = (|meas_i.viol) || meas_i.diag_fail;
    assign mff_meas = meas_i.diag_fail ? lhr_pkg::ALL_FAULT : (mff | meas_i.viol);

    // Receive path: assemble and check
    always_comb begin
        logic [2:0] idx;
        idx = rx_first_i ? 3'h0 : rx_idx;
        next_rx_buf = rx_buf;
        next_rx_idx = rx_idx;
        rx_done = 1'b0;
        if (rx_valid_i) begin
            next_rx_buf[idx] = rx_data_i;
            next_rx_idx = idx + 3'h1;
            rx_done = (idx == lhr_pkg::IDX_DCHK1);
        end
    end

    lhr_pec u_rx_cpec (
        .seed_i(lhr_pkg::CMD_SEED),
        .byte0_i(next_rx_buf[lhr_pkg::IDX_CMD0]),
        .byte1_i(next_rx_buf[lhr_pkg::IDX_CMD1]),
        .check_o(rx_cchk)
    );

    lhr_pec u_rx_dpec (
        .seed_i(lhr_pkg::DATA_SEED),
        .byte0_i(next_rx_buf[lhr_pkg::IDX_COUNT]),
        .byte1_i(next_rx_buf[lhr_pkg::IDX_FLAGS]),
        .check_o(rx_dchk)
    );

    assign rx_ok = ({next_rx_buf[lhr_pkg::IDX_CMD0], next_rx_buf[lhr_pkg::IDX_CMD1]} == lhr_pkg::HB_CMD_CODE)
        && ({next_rx_buf[lhr_pkg::IDX_CCHK0], next_rx_buf[lhr_pkg::IDX_CCHK1]} == rx_cchk)
        && ({next_rx_buf[lhr_pkg::IDX_DCHK0], next_rx_buf[lhr_pkg::IDX_DCHK1]} == rx_dchk);
    assign rx_bad = rx_done && !rx_ok && active;
    // A relay busy with a frame ignores the next one; an originator that is not also terminator ignores all
    assign rx_take = rx_done && rx_ok && active && (term || (!orig && state == lhr_pkg::ST_IDLE));
    assign next_last_rx = rx_take ? {next_rx_buf[lhr_pkg::IDX_COUNT], next_rx_buf[lhr_pkg::IDX_FLAGS]} : last_rx;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= 8'h00;
            end
            rx_idx <= 3'h0;
            last_rx <= '0;
        end else begin
            rx_buf <= next_rx_buf;
            rx_idx <= next_rx_idx;
            last_rx <= next_last_rx;
        end
    end

    // Sequencer: wait, measure, regenerate, send
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_in_pl = in_pl;
        next_tx_pl = tx_pl;
        next_tx_idx = tx_idx;
        meas_start_o = 1'b0;
        hb_sent = 1'b0;
        case (state)
            lhr_pkg::ST_IDLE: begin
                if (rx_take && !term) begin
                    next_in_pl = next_last_rx;
                    next_state = lhr_pkg::ST_MEAS;
                    meas_start_o = 1'b1;
                end
            end
            lhr_pkg::ST_WAIT: begin
                if (timer == 32'h0000_0000) begin
                    next_in_pl = {chain_len, lhr_pkg::PASS_FLAGS};
                    next_state = lhr_pkg::ST_MEAS;
                    meas_start_o = 1'b1;
                end else begin
                    next_timer = timer - 32'h0000_0001;
                end
            end
            lhr_pkg::ST_MEAS: begin
                if (meas_i.done) begin
                    next_tx_pl.count = own_fail ? in_pl.count : 8'(in_pl.count - 8'h01);
                    next_tx_pl.flags = in_pl.flags | mff_meas;
                    next_tx_idx = lhr_pkg::IDX_CMD0;
                    next_state = lhr_pkg::ST_SEND;
                end
            end
            lhr_pkg::ST_SEND: begin
                if (tx_ready_i) begin
                    if (tx_idx == lhr_pkg::IDX_DCHK1) begin
                        hb_sent = 1'b1;
                        if (orig) begin
                            next_timer = PERIOD_CYC - 32'h0000_0001;
                            next_state = lhr_pkg::ST_WAIT;
                        end else begin
                            next_state = lhr_pkg::ST_IDLE;
                        end
                    end else begin
                        next_tx_idx = tx_idx + 3'h1;
                    end
                end
            end
            default: begin
                next_state = lhr_pkg::ST_IDLE;
            end
        endcase
        if (cmd_dis) begin
            next_state = lhr_pkg::ST_IDLE;
        end else if (cmd_en && orig && !active) begin
            next_timer = FIRST_CYC - 32'h0000_0001;
            next_state = lhr_pkg::ST_WAIT;
        end
    end

    lhr_pec u_tx_cpec (
        .seed_i(lhr_pkg::CMD_SEED),
        .byte0_i(lhr_pkg::HB_CMD_CODE[15:8]),
        .byte1_i(lhr_pkg::HB_CMD_CODE[7:0]),
        .check_o(tx_cchk)
    );

    lhr_pec u_tx_dpec (
        .seed_i(lhr_pkg::DATA_SEED),
        .byte0_i(next_tx_pl.count),
        .byte1_i(next_tx_pl.flags),
        .check_o(tx_dchk)
    );

    assign tx_frame[lhr_pkg::IDX_CMD0] = lhr_pkg::HB_CMD_CODE[15:8];
    assign tx_frame[lhr_pkg::IDX_CMD1] = lhr_pkg::HB_CMD_CODE[7:0];
    assign tx_frame[lhr_pkg::IDX_CCHK0] = tx_cchk[15:8];
    assign tx_frame[lhr_pkg::IDX_CCHK1] = tx_cchk[7:0];
    assign tx_frame[lhr_pkg::IDX_COUNT] = next_tx_pl.count;
    assign tx_frame[lhr_pkg::IDX_FLAGS] = next_tx_pl.flags;
    assign tx_frame[lhr_pkg::IDX_DCHK0] = tx_dchk[15:8];
    assign tx_frame[lhr_pkg::IDX_DCHK1] = tx_dchk[7:0];
    assign next_tx_data = tx_frame[next_tx_idx];

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= lhr_pkg::ST_IDLE;
            timer <= 32'h0000_0000;
            in_pl <= '0;
            tx_pl <= '0;
            tx_idx <= 3'h0;
            tx_data <= 8'h00;
        end else begin
            state <= next_state;
            timer <= next_timer;
            in_pl <= next_in_pl;
            tx_pl <= next_tx_pl;
            tx_idx <= next_tx_idx;
            tx_data <= next_tx_data;
        end
    end

    assign tx_valid_o = (state == lhr_pkg::ST_SEND);
    assign tx_data_o = tx_data;

    // Chain end evaluation and timeout
    always_comb begin
        next_term_fault = term_fault;
        next_tmo_cnt = tmo_cnt;
        term_fail_ev = 1'b0;
        tmo_ev = 1'b0;
        if (active && term) begin
            if (tmo_cnt == 32'h0000_0000) begin
                tmo_ev = 1'b1;
                next_tmo_cnt = TMO_CYC - 32'h0000_0001;
            end else begin
                next_tmo_cnt = tmo_cnt - 32'h0000_0001;
            end
            if (rx_take) begin
                if (next_last_rx == {lhr_pkg::PASS_COUNT, lhr_pkg::PASS_FLAGS}) begin
                    next_tmo_cnt = TMO_CYC - 32'h0000_0001;
                    next_term_fault = 1'b0;
                end else begin
                    term_fail_ev = 1'b1;
                end
            end
            if (term_fail_ev || tmo_ev) begin
                next_term_fault = 1'b1;
            end
        end
        // Indication is raised on enable until a first pass arrives
        if (cmd_en && term && !active) begin
            next_term_fault = 1'b1;
            next_tmo_cnt = TMO_CYC - 32'h0000_0001;
        end else if (cmd_dis) begin
            next_term_fault = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            term_fault <= 1'b0;
            tmo_cnt <= 32'h0000_0000;
        end else begin
            term_fault <= next_term_fault;
            tmo_cnt <= next_tmo_cnt;
        end
    end

    assign wake_o = term_fault;

    // Register file and interrupt
    assign events[lhr_pkg::IRQ_REJ] = rx_bad;
    assign events[lhr_pkg::IRQ_SENT] = hb_sent;
    assign events[lhr_pkg::IRQ_FAIL] = term_fail_ev;
    assign events[lhr_pkg::IRQ_TMO] = tmo_ev;

    always_comb begin
        next_orig = orig;
        next_term = term;
        next_len = chain_len;
        next_mask = irq_mask;
        next_active = active;
        next_mff = mff;
        next_ist = irq_st;
        next_rdata = 32'h0000_0000;
        // Role bits are frozen while monitoring runs
        if (wr_hit(bus_i, lhr_pkg::REG_CTRL) && !active) begin
            next_orig = bus_i.wdata[lhr_pkg::CTRL_ORIG];
            next_term = bus_i.wdata[lhr_pkg::CTRL_TERM];
        end
        if (wr_hit(bus_i, lhr_pkg::REG_LEN)) begin
            next_len = bus_i.wdata[7:0];
        end
        if (wr_hit(bus_i, lhr_pkg::REG_IMASK)) begin
            next_mask = bus_i.wdata[IRQ_W_M1:0];
        end
        if (wr_hit(bus_i, lhr_pkg::REG_IST)) begin
            next_ist = irq_st & ~bus_i.wdata[IRQ_W_M1:0];
        end
        next_ist = next_ist | events;
        if (cmd_dis) begin
            next_active = 1'b0;
        end else if (cmd_en) begin
            next_active = 1'b1;
        end
        if (clr_wr) begin
            next_mff = mff & ~clr_mask;
        end
        // A violation in the clear cycle still lands; diagnostics can refill all ones
        if (meas_take) begin
            next_mff = meas_i.diag_fail ? lhr_pkg::ALL_FAULT : (next_mff | meas_i.viol);
        end
        if (bus_i.rd) begin
            case (bus_i.addr)
                lhr_pkg::REG_CTRL: next_rdata = {30'h0000_0000, term, orig};
                lhr_pkg::REG_LEN: next_rdata = {24'h00_0000, chain_len};
                lhr_pkg::REG_MFF: next_rdata = {24'h00_0000, mff};
                lhr_pkg::REG_LASTRX: next_rdata = {16'h0000, last_rx};
                lhr_pkg::REG_IST: next_rdata = {28'h000_0000, irq_st};
                lhr_pkg::REG_IMASK: next_rdata = {28'h000_0000, irq_mask};
                lhr_pkg::REG_STAT: next_rdata = {28'h000_0000, term_fault, active, state};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            orig <= 1'b0;
            term <= 1'b0;
            chain_len <= lhr_pkg::LEN_RST;
            irq_mask <= '0;
            irq_st <= '0;
            active <= 1'b0;
            mff <= 8'h00;
            rdata <= 32'h0000_0000;
        end else begin
            orig <= next_orig;
            term <= next_term;
            chain_len <= next_len;
            irq_mask <= next_mask;
            irq_st <= next_ist;
            active <= next_active;
            mff <= next_mff;
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;
    assign irq_o = |(irq_st & irq_mask);
    assign monitoring_o = active;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    property p_reject;
        rx_done && !rx_ok && state == lhr_pkg::ST_IDLE |=> state == lhr_pkg::ST_IDLE;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame started a cycle");

    property p_wait_orig;
        state == lhr_pkg::ST_WAIT |-> orig;
    endproperty
    a_wait_orig: assert property (p_wait_orig) else $error("non-originator timing a launch");

    property p_send_after_meas;
        $rose(tx_valid_o) |-> $past(meas_take) && $past(state) == lhr_pkg::ST_MEAS;
    endproperty
    a_send_after_meas: assert property (p_send_after_meas) else $error("frame sent before measurement");

    property p_sticky;
        !clr_wr |=> ($past(mff) & ~mff) == 8'h00;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared without clear command");

    property p_diag;
        meas_take && meas_i.diag_fail |=> mff == lhr_pkg::ALL_FAULT;
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostic did not force all ones");

    property p_count;
        meas_take |=> tx_pl.count == ($past(own_fail) ? $past(in_pl.count) : 8'($past(in_pl.count) - 8'h01));
    endproperty
    a_count: assert property (p_count) else $error("wrong outgoing count");

    property p_merge;
        meas_take |=> (tx_pl.flags & $past(in_pl.flags | meas_i.viol)) == $past(in_pl.flags | meas_i.viol);
    endproperty
    a_merge: assert property (p_merge) else $error("flags lost in merge");

    property p_term_fail;
        rx_take && term && next_last_rx != {lhr_pkg::PASS_COUNT, lhr_pkg::PASS_FLAGS} && !cmd_dis |=> wake_o;
    endproperty
    a_term_fail: assert property (p_term_fail) else $error("bad payload did not raise wake");

    property p_first;
        cmd_en && orig && !active |=> state == lhr_pkg::ST_WAIT && timer == FIRST_CYC - 1;
    endproperty
    a_first: assert property (p_first) else $error("first launch delay not loaded");
endmodule
